//--- logic/rcr_cfg.svh
`ifndef RCR_CFG_SVH
`define RCR_CFG_SVH
// Reset vector table slots
`define RCR_RST_VEC_PC   32'h0000_0000
`define RCR_RST_VEC_SP   32'h0000_0004
// Reset values
`define RCR_VBR_RST      32'h0000_0000
`define RCR_SR_RST       32'h0000_00F0
// Status word layout
`define RCR_SR_T         0
`define RCR_SR_IMSK_LO   4
`define RCR_SR_IMSK_HI   7
`define RCR_SR_WMASK     32'h0000_03F3
// Fixed general register roles
`define RCR_IDX_GPR      4'h0
`define RCR_SP_GPR       4'hF
// Exception vector taken on a misaligned access
`define RCR_VEC_ADDR_ERR 8'h09
// Instruction and stack step sizes in bytes
`define RCR_INSN_BYTES   32'h0000_0002
`define RCR_STK_BYTES    32'h0000_0004
// Multiply latencies in cycles, counting the issue cycle
`define RCR_LAT_MULW     3'h2
`define RCR_LAT_MACW     3'h3
`define RCR_LAT_MULL     3'h4
`define RCR_LAT_ACCUM_LOW     3'h4
`endif

//--- logic/rcr_pkg.sv
`default_nettype none
package rcr_pkg;
	typedef enum logic [1:0] {SZ_B, SZ_W, SZ_L} rcr_size_t;
	typedef enum logic [1:0] {AM_IND, AM_IDX, AM_GBR, AM_PC} rcr_am_t;
	typedef enum logic [1:0] {MK_MULW, MK_MACW, MK_MULL, MK_ACCUM_LOW} rcr_mk_t;
	typedef enum logic [4:0] {
		OP_NOP, OP_MOVI, OP_ADDI, OP_CMPEQI, OP_TSTI, OP_ANDI, OP_ORI,
		OP_XORI, OP_MOVR, OP_ADD, OP_LOAD, OP_STORE, OP_ANDM, OP_BRA,
		OP_BC, OP_BCS, OP_JSR, OP_RTS, OP_LDC, OP_STC, OP_MUL, OP_TRAP
	} rcr_op_t;
	// One decoded 16-bit instruction word
	typedef struct packed {
		logic        valid;
		rcr_op_t     op;
		rcr_am_t     am;
		rcr_size_t   size;
		logic [3:0]  rn;
		logic [3:0]  rm;
		logic [7:0]  imm;
	} rcr_cmd_t;
	typedef struct packed {
		logic        valid;
		logic        write;
		rcr_size_t   size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} rcr_mreq_t;
	typedef struct packed {
		logic        valid;
		logic [31:0] rdata;
	} rcr_mrsp_t;
endpackage : rcr_pkg
`default_nettype wire

//--- logic/rcr_opfmt.sv
`timescale 1ns/1ps
`default_nettype none
module rcr_opfmt
	import rcr_pkg::*;
(
	input  wire rcr_size_t   ld_sz_i,
	input  wire logic [31:0] ld_raw_i,
	input  wire rcr_size_t   ac_sz_i,
	input  wire logic [31:0] ac_addr_i,
	input  wire logic [7:0]  imm_i,
	output logic [31:0]      ld_ext_o,
	output logic [31:0]      simm_o,
	output logic [31:0]      zimm_o,
	output logic             misalign_o
);
	// Narrow loads widen by sign, data sits in the low lanes
	always_comb begin
		case (ld_sz_i)
			SZ_B:    ld_ext_o = {{24{ld_raw_i[7]}}, ld_raw_i[7:0]};
			SZ_W:    ld_ext_o = {{16{ld_raw_i[15]}}, ld_raw_i[15:0]};
			default: ld_ext_o = ld_raw_i;
		endcase
	end

	// Arithmetic forms sign-extend, logic forms zero-extend
	assign simm_o = {{24{imm_i[7]}}, imm_i};
	assign zimm_o = {24'h00_0000, imm_i};

	// Bytes go anywhere; words need 2n, longs 4n
	always_comb begin
		case (ac_sz_i)
			SZ_W:    misalign_o = ac_addr_i[0];
			SZ_L:    misalign_o = |ac_addr_i[1:0];
			default: misalign_o = 1'b0;
		endcase
	end
endmodule : rcr_opfmt
`default_nettype wire

//--- logic/rcr_mul.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcr_cfg.svh"
module rcr_mul
	import rcr_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic        start_i,
	input  wire rcr_mk_t     kind_i,
	input  wire logic [31:0] a_i,
	input  wire logic [31:0] b_i,
	input  wire logic [63:0] acc_i,
	output logic             done_o,
	output logic [63:0]      res_o
);
	typedef struct packed {
		logic        busy;
		logic [2:0]  cnt;
		logic [63:0] res;
	} rcr_mul_st_t;

	rcr_mul_st_t        s_q;
	rcr_mul_st_t        s_d;
	logic signed [31:0] pw;
	logic signed [63:0] pl;

	// Result is formed at issue; the counter only paces completion
	always_comb begin
		s_d = s_q;
		pw  = $signed({{16{a_i[15]}}, a_i[15:0]}) * $signed({{16{b_i[15]}}, b_i[15:0]});
		pl  = $signed({{32{a_i[31]}}, a_i}) * $signed({{32{b_i[31]}}, b_i});
		if (start_i) begin
			s_d.busy = 1'b1;
			case (kind_i)
				MK_MULW: begin
					s_d.res = {acc_i[63:32], pw};
					s_d.cnt = `RCR_LAT_MULW - 3'h1;
				end
				MK_MACW: begin
					s_d.res = acc_i + {{32{pw[31]}}, pw};
					s_d.cnt = `RCR_LAT_MACW - 3'h1;
				end
				MK_MULL: begin
					s_d.res = pl;
					s_d.cnt = `RCR_LAT_MULL - 3'h1;
				end
				default: begin
					s_d.res = acc_i + pl;
					s_d.cnt = `RCR_LAT_ACCUM_LOW - 3'h1;
				end
			endcase
		end else if (s_q.busy) begin
			s_d.cnt = s_q.cnt - 3'h1;
			if (s_q.cnt == 3'h1) begin
				s_d.busy = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done_o = s_q.busy && (s_q.cnt == 3'h1);
	assign res_o  = s_q.res;
endmodule : rcr_mul
`default_nettype wire

//--- logic/rcr_regset.sv
// Function
// - Sixteen 32-bit general registers, three control and four system registers.
// - General register zero is the index and fixed-operand register.
// - Register fifteen is the stack pointer; exceptions push status and PC.
// - Global base register is the base for global-base-relative accesses.
// - Vector base register is the base of the exception vector area.
// - Accumulators hold multiply results, return register, PC tracks instructions.
// - Reset loads PC and SP from vector table, clears vector base.
// - Reset sets interrupt mask to ones and clears reserved status bits.
// - Register operands are 32 bits; narrow loads are sign-extended.
// - Misaligned word or long accesses raise an address error.
// - Stack holds only aligned 32-bit words.
// - Eight-bit immediates sign-extend for move, add and compare-equal.
// - Eight-bit immediates zero-extend for test, and, or, exclusive-or.
// - Wide immediates come from a PC-relative memory table.
// - Every instruction is one 16-bit word.
// - Basic instructions complete one per clock.
// - Arithmetic is register to register; bit logic may touch memory.
// - Unconditional branches run the next instruction before transferring.
// - Conditional branches come delayed and ordinary.
// - Short multiply takes one to two cycles, short accumulate two to three.
// - Long multiply, with or without accumulate, takes two to four cycles.
`timescale 1ns/1ps
`default_nettype none
`include "rcr_cfg.svh"
module rcr_regset
	import rcr_pkg::*;
#(
	parameter int GPR_NUM = 16
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire rcr_cmd_t    cmd_i,
	output logic             cmd_ready_o,
	output logic [31:0]      pc_o,
	output rcr_mreq_t        mem_req_o,
	input  wire rcr_mrsp_t   mem_rsp_i,
	input  wire logic [4:0]  rd_sel_i,
	output logic [31:0]      rd_data_o,
	output logic [31:0]      status_word_o,
	output logic [3:0]       interrupt_mask_field_o,
	output logic             addr_err_o
);
	typedef enum logic [3:0] {
		ST_RPC, ST_RSP, ST_RUN, ST_LOAD, ST_STORE,
		ST_PSR, ST_PPC, ST_VEC, ST_MUL
	} rcr_st_t;

	typedef struct packed {
		rcr_st_t                  st;
		logic [GPR_NUM-1:0][31:0] gpr;
		logic [31:0]              status_word;
		logic [31:0]              global_base_reg;
		logic [31:0]              vector_base_reg;
		logic [31:0]              accum_high;
		logic [31:0]              accum_low;
		logic [31:0]              return_address_reg;
		logic [31:0]              pc;
		logic                     slot;
		logic [31:0]              tgt;
		logic                     rdy;
		rcr_mreq_t                mreq;
		logic [3:0]               ld_rn;
		rcr_size_t                ld_sz;
		logic                     rmw;
		logic [7:0]               rmw_imm;
		logic [7:0]               vec;
		logic                     aerr;
		logic [31:0]              rdat;
	} rcr_state_t;

	rcr_state_t  s_q;
	rcr_state_t  s_d;
	logic [31:0] ea;
	logic [31:0] disp_sc;
	logic [31:0] btgt;
	logic [31:0] sp_al;
	logic [31:0] r0;
	logic [31:0] rn_v;
	logic [31:0] rm_v;
	logic [31:0] ld_ext;
	logic [31:0] simm;
	logic [31:0] zimm;
	logic        misalign;
	rcr_size_t   ac_sz;
	logic        mul_go;
	logic        mul_done;
	logic [63:0] mul_res;
	logic        exc_go;
	logic        mem_go;
	logic        take;

	assign r0   = s_q.gpr[`RCR_IDX_GPR];
	assign rn_v = s_q.gpr[cmd_i.rn];
	assign rm_v = s_q.gpr[cmd_i.rm];
	assign take = cmd_i.valid && s_q.rdy && (s_q.st == ST_RUN);

	// Stack pointer forced to a word boundary before each push
	assign sp_al   = {s_q.gpr[`RCR_SP_GPR][31:2], 2'b00} - `RCR_STK_BYTES;
	// Displacements scale with access size; branches count halfwords
	assign disp_sc = {24'h00_0000, cmd_i.imm} << cmd_i.size;
	assign btgt    = s_q.pc + (`RCR_INSN_BYTES << 1) + {{23{cmd_i.imm[7]}}, cmd_i.imm, 1'b0};
	assign ac_sz   = (cmd_i.op == OP_ANDM) ? SZ_B : cmd_i.size;

	// Effective address of the access offered this cycle
	always_comb begin
		case (cmd_i.am)
			AM_IDX:  ea = rm_v + r0;
			AM_GBR:  ea = s_q.global_base_reg + disp_sc;
			AM_PC: begin
				// Long table entries sit on the aligned word past PC
				if (cmd_i.size == SZ_L) begin
					ea = {s_q.pc[31:2], 2'b00} + (`RCR_INSN_BYTES << 1) + disp_sc;
				end else begin
					ea = s_q.pc + (`RCR_INSN_BYTES << 1) + disp_sc;
				end
			end
			default: ea = rm_v;
		endcase
		if (cmd_i.op == OP_ANDM) begin
			ea = s_q.global_base_reg + r0;
		end
	end

	rcr_opfmt u_fmt (
		.ld_sz_i    (s_q.ld_sz),
		.ld_raw_i   (mem_rsp_i.rdata),
		.ac_sz_i    (ac_sz),
		.ac_addr_i  (ea),
		.imm_i      (cmd_i.imm),
		.ld_ext_o   (ld_ext),
		.simm_o     (simm),
		.zimm_o     (zimm),
		.misalign_o (misalign)
	);

	rcr_mul u_mul (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.start_i   (mul_go),
		.kind_i    (rcr_mk_t'(cmd_i.imm[1:0])),
		.a_i       (rn_v),
		.b_i       (rm_v),
		.acc_i     ({s_q.accum_high, s_q.accum_low}),
		.done_o    (mul_done),
		.res_o     (mul_res)
	);

	// Sequencer: reset fetch, execute, memory waits, exception entry
	always_comb begin
		s_d    = s_q;
		mul_go = 1'b0;
		exc_go = 1'b0;
		mem_go = 1'b0;
		s_d.aerr = 1'b0;
		case (s_q.st)
			ST_RPC: begin
				if (mem_rsp_i.valid) begin
					s_d.pc        = mem_rsp_i.rdata;
					s_d.mreq.addr = `RCR_RST_VEC_SP;
					s_d.st        = ST_RSP;
				end
			end
			ST_RSP: begin
				if (mem_rsp_i.valid) begin
					s_d.gpr[`RCR_SP_GPR] = mem_rsp_i.rdata;
					s_d.mreq.valid       = 1'b0;
					s_d.st               = ST_RUN;
					s_d.rdy              = 1'b1;
				end
			end
			ST_RUN: begin
				if (take) begin
					// A pending delay slot redirects after this one
					s_d.pc   = s_q.slot ? s_q.tgt : s_q.pc + `RCR_INSN_BYTES;
					s_d.slot = 1'b0;
					case (cmd_i.op)
						OP_MOVI:   s_d.gpr[cmd_i.rn] = simm;
						OP_ADDI:   s_d.gpr[cmd_i.rn] = rn_v + simm;
						OP_CMPEQI: s_d.status_word[`RCR_SR_T] = (r0 == simm);
						OP_TSTI:   s_d.status_word[`RCR_SR_T] = ((r0 & zimm) == 32'h0);
						OP_ANDI:   s_d.gpr[`RCR_IDX_GPR] = r0 & zimm;
						OP_ORI:    s_d.gpr[`RCR_IDX_GPR] = r0 | zimm;
						OP_XORI:   s_d.gpr[`RCR_IDX_GPR] = r0 ^ zimm;
						OP_MOVR:   s_d.gpr[cmd_i.rn] = rm_v;
						OP_ADD:    s_d.gpr[cmd_i.rn] = rn_v + rm_v;
						OP_LOAD, OP_STORE, OP_ANDM: begin
							if (misalign) begin
								s_d.aerr = 1'b1;
								s_d.vec  = `RCR_VEC_ADDR_ERR;
								exc_go   = 1'b1;
							end else begin
								mem_go = 1'b1;
							end
						end
						OP_BRA: begin
							s_d.slot = 1'b1;
							s_d.tgt  = btgt;
						end
						OP_BC: begin
							// Ordinary form: no slot, redirect at once
							if (s_q.status_word[`RCR_SR_T] == cmd_i.rn[0]) begin
								s_d.pc = btgt;
							end
						end
						OP_BCS: begin
							if (s_q.status_word[`RCR_SR_T] == cmd_i.rn[0]) begin
								s_d.slot = 1'b1;
								s_d.tgt  = btgt;
							end
						end
						OP_JSR: begin
							s_d.return_address_reg = s_q.pc + (`RCR_INSN_BYTES << 1);
							s_d.slot = 1'b1;
							s_d.tgt  = rm_v;
						end
						OP_RTS: begin
							s_d.slot = 1'b1;
							s_d.tgt  = s_q.return_address_reg;
						end
						OP_LDC: begin
							case (cmd_i.imm[2:0])
								3'h0: s_d.status_word = rm_v & `RCR_SR_WMASK;
								3'h1: s_d.global_base_reg = rm_v;
								3'h2: s_d.vector_base_reg = rm_v;
								3'h3: s_d.accum_high = rm_v;
								3'h4: s_d.accum_low = rm_v;
								default: s_d.return_address_reg = rm_v;
							endcase
						end
						OP_STC: begin
							case (cmd_i.imm[2:0])
								3'h0: s_d.gpr[cmd_i.rn] = s_q.status_word;
								3'h1: s_d.gpr[cmd_i.rn] = s_q.global_base_reg;
								3'h2: s_d.gpr[cmd_i.rn] = s_q.vector_base_reg;
								3'h3: s_d.gpr[cmd_i.rn] = s_q.accum_high;
								3'h4: s_d.gpr[cmd_i.rn] = s_q.accum_low;
								default: s_d.gpr[cmd_i.rn] = s_q.return_address_reg;
							endcase
						end
						OP_MUL: begin
							mul_go  = 1'b1;
							s_d.st  = ST_MUL;
							s_d.rdy = 1'b0;
						end
						OP_TRAP: begin
							s_d.vec = cmd_i.imm;
							exc_go  = 1'b1;
						end
						default: s_d.st = ST_RUN;
					endcase
				end
			end
			ST_LOAD: begin
				if (mem_rsp_i.valid) begin
					if (s_q.rmw) begin
						// Bit logic straight on memory: write the result back
						s_d.mreq.write = 1'b1;
						s_d.mreq.wdata = {24'h00_0000, mem_rsp_i.rdata[7:0] & s_q.rmw_imm};
						s_d.st         = ST_STORE;
					end else begin
						s_d.gpr[s_q.ld_rn] = ld_ext;
						s_d.mreq.valid     = 1'b0;
						s_d.st             = ST_RUN;
						s_d.rdy            = 1'b1;
					end
				end
			end
			ST_STORE: begin
				if (mem_rsp_i.valid) begin
					s_d.mreq.valid = 1'b0;
					s_d.st         = ST_RUN;
					s_d.rdy        = 1'b1;
				end
			end
			ST_PSR: begin
				if (mem_rsp_i.valid) begin
					s_d.gpr[`RCR_SP_GPR] = sp_al;
					s_d.mreq.addr        = sp_al - `RCR_STK_BYTES;
					s_d.mreq.wdata       = s_q.pc;
					s_d.st               = ST_PPC;
				end
			end
			ST_PPC: begin
				if (mem_rsp_i.valid) begin
					s_d.gpr[`RCR_SP_GPR] = sp_al;
					s_d.mreq.write       = 1'b0;
					s_d.mreq.addr        = s_q.vector_base_reg + {22'h00_0000, s_q.vec, 2'b00};
					s_d.st               = ST_VEC;
				end
			end
			ST_VEC: begin
				if (mem_rsp_i.valid) begin
					s_d.pc         = mem_rsp_i.rdata;
					s_d.mreq.valid = 1'b0;
					s_d.st         = ST_RUN;
					s_d.rdy        = 1'b1;
				end
			end
			ST_MUL: begin
				if (mul_done) begin
					s_d.accum_high = mul_res[63:32];
					s_d.accum_low  = mul_res[31:0];
					s_d.st         = ST_RUN;
					s_d.rdy        = 1'b1;
				end
			end
			default: s_d.st = ST_RPC;
		endcase

		// Access launch; loads and stores hold the core until memory answers
		if (mem_go) begin
			s_d.mreq.valid = 1'b1;
			s_d.mreq.write = (cmd_i.op == OP_STORE);
			s_d.mreq.size  = ac_sz;
			s_d.mreq.addr  = ea;
			s_d.mreq.wdata = rn_v;
			s_d.ld_rn      = cmd_i.rn;
			s_d.ld_sz      = ac_sz;
			s_d.rmw        = (cmd_i.op == OP_ANDM);
			s_d.rmw_imm    = cmd_i.imm;
			s_d.st         = (cmd_i.op == OP_STORE) ? ST_STORE : ST_LOAD;
			s_d.rdy        = 1'b0;
		end

		// Exception entry: push status word first, then PC
		if (exc_go) begin
			s_d.mreq.valid = 1'b1;
			s_d.mreq.write = 1'b1;
			s_d.mreq.size  = SZ_L;
			s_d.mreq.addr  = sp_al;
			s_d.mreq.wdata = s_q.status_word;
			s_d.slot       = 1'b0;
			s_d.st         = ST_PSR;
			s_d.rdy        = 1'b0;
		end

		// Observation port, one cycle behind the select
		case (rd_sel_i)
			5'h10:   s_d.rdat = s_q.status_word;
			5'h11:   s_d.rdat = s_q.global_base_reg;
			5'h12:   s_d.rdat = s_q.vector_base_reg;
			5'h13:   s_d.rdat = s_q.accum_high;
			5'h14:   s_d.rdat = s_q.accum_low;
			5'h15:   s_d.rdat = s_q.return_address_reg;
			5'h16:   s_d.rdat = s_q.pc;
			default: s_d.rdat = rd_sel_i[4] ? 32'h0000_0000 : s_q.gpr[rd_sel_i[3:0]];
		endcase
	end

	// Undefined-at-reset registers are cleared too, for clean simulation
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s_q                 <= '0;
			s_q.st              <= ST_RPC;
			s_q.status_word     <= `RCR_SR_RST;
			s_q.vector_base_reg <= `RCR_VBR_RST;
			s_q.mreq.valid      <= 1'b1;
			s_q.mreq.size       <= SZ_L;
			s_q.mreq.addr       <= `RCR_RST_VEC_PC;
		end else begin
			s_q <= s_d;
		end
	end

	assign cmd_ready_o            = s_q.rdy;
	assign pc_o                   = s_q.pc;
	assign mem_req_o              = s_q.mreq;
	assign rd_data_o              = s_q.rdat;
	assign status_word_o          = s_q.status_word;
	assign interrupt_mask_field_o = s_q.status_word[`RCR_SR_IMSK_HI:`RCR_SR_IMSK_LO];
	assign addr_err_o             = s_q.aerr;
endmodule : rcr_regset
`default_nettype wire

//--- sim/rcr_regset_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rcr_regset_monitor
	import rcr_pkg::*;
#(
	parameter int GPR_NUM = 16
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire rcr_cmd_t    cmd_i,
	input  wire logic        cmd_ready_o,
	input  wire logic [31:0] pc_o,
	input  wire rcr_mreq_t   mem_req_o,
	input  wire rcr_mrsp_t   mem_rsp_i,
	input  wire logic [31:0] status_word_o,
	input  wire logic [3:0]  interrupt_mask_field_o,
	input  wire logic        addr_err_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	logic take;
	logic br_q;
	assign take = cmd_i.valid && cmd_ready_o;
	// Remember flow changes, the next slot does not step by two
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) br_q <= 1'b0;
		else if (take) br_q <= cmd_i.op inside {OP_BRA, OP_BC, OP_BCS, OP_JSR, OP_RTS, OP_TRAP};
	end
	sequence s_basic;
		take && !br_q && cmd_i.op inside {OP_NOP, OP_MOVI, OP_ADDI, OP_CMPEQI, OP_TSTI, OP_ANDI, OP_ORI, OP_XORI};
	endsequence
	sequence s_mul(k);
		take && cmd_i.op == OP_MUL && cmd_i.imm[1:0] == k;
	endsequence
	AST_RST_STATUS: assert property (disable iff (1'b0)
		rst_i |=> status_word_o == 32'h0000_00F0 && interrupt_mask_field_o == 4'hF && !cmd_ready_o)
		else $error("Status word or ready wrong in reset");
	AST_MASK_COPY: assert property (interrupt_mask_field_o == status_word_o[7:4])
		else $error("Mask output differs from status word");
	AST_RSVD_ZERO: assert property ((status_word_o & ~32'h0000_03F3) == 32'h0)
		else $error("Reserved status bit set");
	AST_ALIGN: assert property (mem_req_o.valid |->
		!(mem_req_o.size == SZ_W && mem_req_o.addr[0]) && !(mem_req_o.size == SZ_L && mem_req_o.addr[1:0] != 2'b00))
		else $error("Misaligned request issued");
	AST_ERR_ENTRY: assert property (addr_err_o |-> !cmd_ready_o ##1 (!addr_err_o && !cmd_ready_o))
		else $error("Address error not a pulse into exception entry");
	AST_REQ_HOLD: assert property (mem_req_o.valid && !mem_rsp_i.valid |=> $stable(mem_req_o))
		else $error("Memory request changed before answer");
	AST_PC_STEP: assert property (s_basic |=> pc_o == $past(pc_o) + 32'h2)
		else $error("Program counter did not step by one word");
	AST_ONE_CLK: assert property (s_basic |=> cmd_ready_o)
		else $error("Basic instruction stalled");
	AST_MULW: assert property (s_mul(0) |=> !cmd_ready_o ##1 cmd_ready_o)
		else $error("Short multiply latency wrong");
	AST_MACW: assert property (s_mul(1) |=> (!cmd_ready_o) [*2] ##1 cmd_ready_o)
		else $error("Short accumulate latency wrong");
	AST_MULL: assert property (take && cmd_i.op == OP_MUL && cmd_i.imm[1] |=> (!cmd_ready_o) [*3] ##1 cmd_ready_o)
		else $error("Long multiply latency wrong");
endmodule : rcr_regset_monitor
`default_nettype wire

//--- sim/rcr_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcr_mem_model
	import rcr_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] wait_i,
	input  wire rcr_mreq_t  req_i,
	output rcr_mrsp_t       rsp_o
);
	logic [31:0] mem [0:255];
	logic [3:0]  cnt;
	logic [7:0]  ix;
	logic [4:0]  sh;
	// Big-endian lanes: offset zero is the top byte
	assign ix = req_i.addr[9:2];
	assign sh = (req_i.size == SZ_B) ? {~req_i.addr[1:0], 3'b000} : {~req_i.addr[1], 4'h0};
	// Vector table, handler slot and three data words
	initial begin
		foreach (mem[i]) mem[i] = 32'h0;
		mem[0] = 32'h0000_0040;
		mem[1] = 32'h0000_0200;
		mem[9] = 32'h0000_0080;
		mem[24] = 32'h8001_F2A5;
		mem[38] = 32'h1234_5678;
		mem[39] = 32'h8765_0000;
	end
	// Answers after wait_i extra cycles; idle data toggles so stale values never match
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			rsp_o <= '0;
			cnt <= 4'h0;
		end else if (req_i.valid && !rsp_o.valid && cnt != wait_i) begin
			cnt <= cnt + 4'h1;
		end else if (req_i.valid && !rsp_o.valid) begin
			cnt <= 4'h0;
			rsp_o.valid <= 1'b1;
			if (req_i.write && req_i.size == SZ_B) mem[ix][sh +: 8] <= req_i.wdata[7:0];
			else if (req_i.write && req_i.size == SZ_W) mem[ix][sh +: 16] <= req_i.wdata[15:0];
			else if (req_i.write) mem[ix] <= req_i.wdata;
			if (req_i.size == SZ_B) rsp_o.rdata <= {24'hC3C3C3, mem[ix][sh +: 8]};
			else if (req_i.size == SZ_W) rsp_o.rdata <= {16'h5A5A, mem[ix][sh +: 16]};
			else rsp_o.rdata <= mem[ix];
		end else begin
			rsp_o.valid <= 1'b0;
			rsp_o.rdata <= ~rsp_o.rdata;
		end
	end
endmodule : rcr_mem_model
`default_nettype wire

//--- sim/tb_risc_cpu_register_set.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_risc_cpu_register_set;
	import rcr_pkg::*;
	typedef struct packed {rcr_op_t op; logic [3:0] rn; logic [7:0] imm; logic [4:0] sel; logic [31:0] exp;} rcr_row_t;
	localparam rcr_row_t ROWS [14] = '{
		'{OP_MOVI, 4'h3, 8'h80, 5'h03, 32'hFFFF_FF80}, '{OP_ADDI, 4'h3, 8'hFF, 5'h03, 32'hFFFF_FF7F},
		'{OP_MOVI, 4'h0, 8'hF0, 5'h00, 32'hFFFF_FFF0}, '{OP_ANDI, 4'h0, 8'h8C, 5'h00, 32'h0000_0080},
		'{OP_ORI, 4'h0, 8'h01, 5'h00, 32'h0000_0081}, '{OP_XORI, 4'h0, 8'hFF, 5'h00, 32'h0000_007E},
		'{OP_CMPEQI, 4'h0, 8'h7E, 5'h10, 32'h0000_00F1}, '{OP_CMPEQI, 4'h0, 8'hFE, 5'h10, 32'h0000_00F0},
		'{OP_TSTI, 4'h0, 8'h81, 5'h10, 32'h0000_00F1}, '{OP_MOVI, 4'h5, 8'h11, 5'h05, 32'h0000_0011},
		'{OP_MOVR, 4'h4, 8'h00, 5'h04, 32'h0000_007E}, '{OP_ADD, 4'h4, 8'h00, 5'h04, 32'h0000_00FC},
		'{OP_LDC, 4'h0, 8'h05, 5'h15, 32'h0000_007E}, '{OP_STC, 4'hA, 8'h00, 5'h0A, 32'h0000_00F1}};
	localparam logic [31:0] LAT [4] = '{32'h2, 32'h3, 32'h4, 32'h4};
	logic        sys_clk_i, rst_i, cmd_ready_o, addr_err_o;
	logic [4:0]  rd_sel;
	logic [31:0] rd_data, pc, status;
	logic [3:0]  mask, mem_wait;
	rcr_cmd_t    cmd_i;
	rcr_mreq_t   mem_req;
	rcr_mrsp_t   mem_rsp;
	int          n_errors, cmp_count;
	rcr_regset #(.GPR_NUM(16)) u_dut (.sys_clk_i, .rst_i, .cmd_i, .cmd_ready_o, .pc_o(pc), .mem_req_o(mem_req),
		.mem_rsp_i(mem_rsp), .rd_sel_i(rd_sel), .rd_data_o(rd_data), .status_word_o(status),
		.interrupt_mask_field_o(mask), .addr_err_o);
	rcr_mem_model u_mem (.sys_clk_i, .rst_i, .wait_i(mem_wait), .req_i(mem_req), .rsp_o(mem_rsp));
	function automatic rcr_cmd_t mk(rcr_op_t op, rcr_am_t am, rcr_size_t sz, logic [3:0] rn, logic [3:0] rm,
		logic [7:0] imm);
		mk = '{1'b1, op, am, sz, rn, rm, imm};
	endfunction : mk
	// Offer one instruction and hold it until the core takes it
	task automatic issue(input rcr_cmd_t c);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		cmd_i <= c;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (cmd_ready_o !== 1'b1 && n < 300);
		cmd_i <= '0;
		if (n >= 300) n_errors++;
	endtask : issue
	// Wait until idle, then read back through the one-cycle select path
	task automatic rd(input logic [4:0] s, input logic [31:0] e);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (cmd_ready_o !== 1'b1 && n < 300);
		rd_sel <= s;
		repeat (2) @(posedge sys_clk_i);
		`CHK(rd_data, e)
	endtask : rd
	task automatic summarize;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	// Whole run is a few hundred cycles
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_errors++;
		summarize();
	end
	initial begin
		int n;
		rst_i <= 1'b1;
		cmd_i <= '0;
		rd_sel <= 5'h0;
		mem_wait <= 4'h0;
		n_errors = 0;
		cmp_count = 0;
		repeat (11) @(posedge sys_clk_i);
		`CHK(status, 32'h0000_00F0)
		`CHK(mask, 4'hF)
		@(posedge sys_clk_i);
		rst_i <= 1'b0;
		rd(5'h0F, 32'h0000_0200);
		`CHK(pc, 32'h0000_0040)
		rd(5'h12, 32'h0);
		// Immediate and register forms against the index register and others
		foreach (ROWS[i]) begin
			issue(mk(ROWS[i].op, AM_IND, SZ_L, ROWS[i].rn, 4'h0, ROWS[i].imm));
			rd(ROWS[i].sel, ROWS[i].exp);
		end
		`CHK(pc, 32'h0000_005C)
		rd(5'h17, 32'h0);
		// Slow memory: narrow loads must sign-extend
		mem_wait <= 4'h3;
		issue(mk(OP_LOAD, AM_GBR, SZ_B, 4'h6, 4'h0, 8'h60));
		rd(5'h06, 32'hFFFF_FF80);
		issue(mk(OP_LOAD, AM_GBR, SZ_W, 4'h6, 4'h0, 8'h31));
		rd(5'h06, 32'hFFFF_F2A5);
		issue(mk(OP_LOAD, AM_GBR, SZ_L, 4'h6, 4'h0, 8'h18));
		rd(5'h06, 32'h8001_F2A5);
		for (int k = 0; k < 4; k++) begin
			issue(mk(OP_MUL, AM_IND, SZ_L, 4'h3, 4'h5, 8'(k)));
			n = 0;
			do begin
				@(posedge sys_clk_i);
				n++;
			end while (cmd_ready_o !== 1'b1 && n < 9);
			`CHK(32'(n), LAT[k])
		end
		rd(5'h14, 32'hFFFF_EEDE);
		rd(5'h13, 32'hFFFF_FFFF);
		// Delayed, ordinary and delayed conditional branches
		issue(mk(OP_BRA, AM_IND, SZ_L, 4'h0, 4'h0, 8'h04));
		issue(mk(OP_MOVI, AM_IND, SZ_L, 4'h7, 4'h0, 8'h22));
		rd(5'h07, 32'h0000_0022);
		`CHK(pc, 32'h0000_0076)
		issue(mk(OP_BC, AM_IND, SZ_L, 4'h1, 4'h0, 8'h02));
		rd(5'h17, 32'h0);
		`CHK(pc, 32'h0000_007E)
		issue(mk(OP_BCS, AM_IND, SZ_L, 4'h1, 4'h0, 8'hFE));
		issue(mk(OP_MOVI, AM_IND, SZ_L, 4'h8, 4'h0, 8'h33));
		rd(5'h08, 32'h0000_0033);
		`CHK(pc, 32'h0000_007E)
		// Odd word address: no access, exception entry through the stack
		issue(mk(OP_MOVI, AM_IND, SZ_L, 4'h2, 4'h0, 8'h61));
		issue(mk(OP_LOAD, AM_IND, SZ_W, 4'h9, 4'h2, 8'h00));
		@(posedge sys_clk_i);
		`CHK(addr_err_o, 1'b1)
		rd(5'h0F, 32'h0000_01F8);
		`CHK(pc, 32'h0000_0080)
		`CHK(u_mem.mem[127], 32'h0000_00F1)
		`CHK(u_mem.mem[126], 32'h0000_0082)
		rd(5'h09, 32'h0);
		// Bit logic on memory, a word store, then the whole word read back
		issue(mk(OP_MOVI, AM_IND, SZ_L, 4'h0, 4'h0, 8'h63));
		issue(mk(OP_ANDM, AM_IDX, SZ_B, 4'h0, 4'h0, 8'h3C));
		issue(mk(OP_STORE, AM_GBR, SZ_W, 4'h8, 4'h0, 8'h30));
		issue(mk(OP_LOAD, AM_GBR, SZ_L, 4'h6, 4'h0, 8'h18));
		rd(5'h06, 32'h0033_F224);
		// Call and return, each with its slot
		issue(mk(OP_JSR, AM_IND, SZ_L, 4'h0, 4'h4, 8'h00));
		issue(mk(OP_MOVI, AM_IND, SZ_L, 4'hB, 4'h0, 8'h44));
		rd(5'h15, 32'h0000_008C);
		`CHK(pc, 32'h0000_00FC)
		issue(mk(OP_RTS, AM_IND, SZ_L, 4'h0, 4'h0, 8'h00));
		issue(mk(OP_MOVI, AM_IND, SZ_L, 4'hC, 4'h0, 8'h55));
		rd(5'h0C, 32'h0000_0055);
		`CHK(pc, 32'h0000_008C)
		// Software trap pushes a second frame below the first
		issue(mk(OP_TRAP, AM_IND, SZ_L, 4'h0, 4'h0, 8'h09));
		rd(5'h0F, 32'h0000_01F0);
		`CHK(u_mem.mem[124], 32'h0000_008E)
		`CHK(pc, 32'h0000_0080)
		// Wide constants past PC; an odd-word PC must still hit the aligned long
		issue(mk(OP_LOAD, AM_PC, SZ_W, 4'hD, 4'h0, 8'h0C));
		issue(mk(OP_LOAD, AM_PC, SZ_L, 4'hE, 4'h0, 8'h05));
		rd(5'h0D, 32'hFFFF_8765);
		rd(5'h0E, 32'h1234_5678);
		// Second reset in mid-run: vectors reload, status returns to its reset value
		@(posedge sys_clk_i);
		rst_i <= 1'b1;
		repeat (12) @(posedge sys_clk_i);
		`CHK(status, 32'h0000_00F0)
		`CHK(cmd_ready_o, 1'b0)
		rst_i <= 1'b0;
		rd(5'h0F, 32'h0000_0200);
		`CHK(pc, 32'h0000_0040)
		summarize();
	end
endmodule : tb_risc_cpu_register_set
bind rcr_regset rcr_regset_monitor #(.GPR_NUM(GPR_NUM)) u_mon (.sys_clk_i, .rst_i, .cmd_i, .cmd_ready_o, .pc_o,
	.mem_req_o, .mem_rsp_i, .status_word_o, .interrupt_mask_field_o, .addr_err_o);
`default_nettype wire
